// File: rtl/ros_mux.sv
/*
  Output selector leaf: picks one source bit and the driver enable.
  Assumes inputs are synchronous to clk and already qualified.
*/
`timescale 1ns/1ps
`default_nettype none
module ros_mux
(
  input  wire ros_pkg::ros_src_t     sel,
  input  wire logic                  powered,
  input  wire ros_pkg::ros_streams_t streams,
  output logic                       bit_out,
  output logic                       drive_en
);
  import ros_pkg::*;

  // Invalid code is folded into mute, so the driver never sends garbage.
  assign drive_en = powered && (sel != ROS_SRC_MUTE)
                    && (sel != ROS_SRC_BAD);

  always_comb begin
    bit_out = 1'b0;
    case (sel)
      ROS_SRC_RAW:    bit_out = streams.raw;
      ROS_SRC_RETIME: bit_out = streams.retimed;
      ROS_SRC_ICLK:   bit_out = streams.iclk;
      ROS_SRC_QCLK:   bit_out = streams.qclk;
      ROS_SRC_PRBS:   bit_out = streams.prbs;
      ROS_SRC_SLOW:   bit_out = streams.slow_clk;
      default:        bit_out = 1'b0;
    endcase
    if (!drive_en) begin
      bit_out = 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: rtl/ros_pkg.sv
/*
  Constants, types and register map for the retimer output source selector.
  Assumes one 200 MHz clock domain and byte-wide register writes from the
  management interface already decoded to an offset, data and strobe.
*/
// Summary of operation
// - Codes 7..0: mute, invalid, slow, PRBS, Q clk, I clk, retimed, raw.
// - No override, signal, no lock: output follows the source field.
// - Source field resets to mute, so unlocked channels stay muted.
// - Without override, a locked channel sends retimed data.
// - Override set: output follows the source field whatever the lock.
// - With no signal detected, the channel and its driver power down.
// - Force bits written one and zero force the signal as detected.
// - Both force bits clear return detection to the automatic circuit.
// - Slow test clock is selectable whenever the output is overridden.
// - No signal: oscillator free-runs and sets the PRBS and clock rates.
// - When locked, the I clock, Q clock and PRBS follow the input.
// - Retimed or raw data with no input gives only noise.
package ros_pkg;

  localparam logic [7:0] ROS_OFF_OVERRIDE  = 8'h09;
  localparam logic [7:0] ROS_OFF_SD_FORCE  = 8'h14;
  localparam logic [7:0] ROS_OFF_SRC_SEL   = 8'h1E;
  localparam logic [7:0] ROS_OFF_CAP_CTRL  = 8'h3F;

  localparam int ROS_BIT_MUX_OVR   = 5;
  localparam int ROS_BIT_QCLK_EN_A = 4;
  localparam int ROS_BIT_QCLK_EN_B = 0;
  localparam int ROS_BIT_PRBS_EN   = 4;
  localparam int ROS_BIT_SD_ON     = 7;
  localparam int ROS_BIT_SD_OFF    = 6;
  localparam int ROS_BIT_CAP_DIS   = 7;
  localparam int ROS_SRC_MSB       = 7;
  localparam int ROS_SRC_LSB       = 5;

  localparam logic [7:0] ROS_RST_OVERRIDE = 8'h00;
  localparam logic [7:0] ROS_RST_SD_FORCE = 8'h00;
  localparam logic [7:0] ROS_RST_SRC_SEL  = 8'hE0;
  localparam logic [7:0] ROS_RST_CAP_CTRL = 8'h00;

  typedef enum logic [2:0] {
    ROS_SRC_RAW    = 3'h0,
    ROS_SRC_RETIME = 3'h1,
    ROS_SRC_ICLK   = 3'h2,
    ROS_SRC_QCLK   = 3'h3,
    ROS_SRC_PRBS   = 3'h4,
    ROS_SRC_SLOW   = 3'h5,
    ROS_SRC_BAD    = 3'h6,
    ROS_SRC_MUTE   = 3'h7
  } ros_src_t;

  typedef struct packed {
    logic raw;
    logic retimed;
    logic iclk;
    logic qclk;
    logic prbs;
    logic slow_clk;
  } ros_streams_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ros_reg_req_t;

endpackage

// File: rtl/ros_top.sv
/*
  Per-channel output source selection with its four control registers.
  Assumes the management interface delivers decoded byte writes and reads
  for the selected channel, and that the stream inputs are produced by the
  CDR, PRBS and oscillator logic, which follow input lock or free-run.
*/
`timescale 1ns/1ps
`default_nettype none
module ros_top
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire ros_pkg::ros_reg_req_t req,
  output logic [7:0]                 rdata_q,
  input  wire logic                  sig_detect_raw,
  input  wire logic                  cdr_locked,
  input  wire ros_pkg::ros_streams_t streams,
  output logic                       tx_data_q,
  output logic                       tx_en_q,
  output logic                       sd_eff_q,
  output logic                       prbs_en_q,
  output logic                       qclk_en_q,
  output logic                       cap_research_dis_q
);
  import ros_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] override_q;
  logic [7:0] sd_force_q;
  logic [7:0] src_sel_q;
  logic [7:0] cap_ctrl_q;

  wire wr_ovr = req.wr && (req.addr == ROS_OFF_OVERRIDE);
  wire wr_sdf = req.wr && (req.addr == ROS_OFF_SD_FORCE);
  wire wr_src = req.wr && (req.addr == ROS_OFF_SRC_SEL);
  wire wr_cap = req.wr && (req.addr == ROS_OFF_CAP_CTRL);

  logic [7:0] rdata_d;
  always_comb begin
    if (req.addr == ROS_OFF_OVERRIDE) begin
      rdata_d = override_q;
    end else if (req.addr == ROS_OFF_SD_FORCE) begin
      rdata_d = sd_force_q;
    end else if (req.addr == ROS_OFF_SRC_SEL) begin
      rdata_d = src_sel_q;
    end else if (req.addr == ROS_OFF_CAP_CTRL) begin
      rdata_d = cap_ctrl_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      override_q <= ROS_RST_OVERRIDE;
      sd_force_q <= ROS_RST_SD_FORCE;
      src_sel_q  <= ROS_RST_SRC_SEL;
      cap_ctrl_q <= ROS_RST_CAP_CTRL;
      rdata_q    <= 8'h00;
    end else if (ce) begin
      if (wr_ovr) override_q <= req.wdata;
      if (wr_sdf) sd_force_q <= req.wdata;
      if (wr_src) src_sel_q  <= req.wdata;
      if (wr_cap) cap_ctrl_q <= req.wdata;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Signal detect and source decision.

  wire force_on  = sd_force_q[ROS_BIT_SD_ON] && !sd_force_q[ROS_BIT_SD_OFF];
  // Other force patterns fall back to the detector; only 10 forces on.
  wire sd_eff    = force_on || sig_detect_raw;
  wire mux_ovr   = override_q[ROS_BIT_MUX_OVR];
  wire ros_src_t field_src = ros_src_t'(src_sel_q[ROS_SRC_MSB:ROS_SRC_LSB]);

  // Locked channels send retimed data unless overridden; the field steers
  // the unlocked case and every overridden case.
  wire ros_src_t eff_src = (mux_ovr || !cdr_locked) ? field_src
                         : ROS_SRC_RETIME;

  logic mux_bit;
  logic mux_en;

  ros_mux u_mux (
    .sel      (eff_src),
    .powered  (sd_eff),
    .streams  (streams),
    .bit_out  (mux_bit),
    .drive_en (mux_en)
  );

  // Enables passed on to the generators; the controller owns their order.
  wire prbs_en = src_sel_q[ROS_BIT_PRBS_EN];
  wire qclk_en = override_q[ROS_BIT_QCLK_EN_A]
               && src_sel_q[ROS_BIT_QCLK_EN_B];
  wire cap_dis = cap_ctrl_q[ROS_BIT_CAP_DIS];

  // One register stage on every output; stream rate and lock relation come
  // from the source logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_q          <= 1'b0;
      tx_en_q            <= 1'b0;
      sd_eff_q           <= 1'b0;
      prbs_en_q          <= 1'b0;
      qclk_en_q          <= 1'b0;
      cap_research_dis_q <= 1'b0;
    end else if (ce) begin
      tx_data_q          <= mux_bit;
      tx_en_q            <= mux_en;
      sd_eff_q           <= sd_eff;
      prbs_en_q          <= prbs_en;
      qclk_en_q          <= qclk_en;
      cap_research_dis_q <= cap_dis;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  no_signal_mute_a: assert property (
    ce && !sig_detect_raw && !force_on |=> !tx_en_q)
    else $error("Driver enabled with no signal detected.");

  locked_retime_a: assert property (
    ce && sd_eff && cdr_locked && !mux_ovr |=>
      tx_en_q && tx_data_q == $past(streams.retimed))
    else $error("Locked channel not sending retimed data.");

  unlock_follow_a: assert property (
    ce && sd_eff && !cdr_locked && !mux_ovr
      && field_src == ROS_SRC_PRBS |=> tx_en_q
      && tx_data_q == $past(streams.prbs))
    else $error("Unlocked output ignores source field.");

  ovr_follow_a: assert property (
    ce && sd_eff && mux_ovr && field_src == ROS_SRC_RAW |=>
      tx_en_q && tx_data_q == $past(streams.raw))
    else $error("Override did not select raw data.");

  slow_clock_a: assert property (
    ce && sd_eff && mux_ovr && field_src == ROS_SRC_SLOW |=>
      tx_data_q == $past(streams.slow_clk))
    else $error("Slow clock not selectable.");

  invalid_mute_a: assert property (
    ce && field_src == ROS_SRC_BAD && (mux_ovr || !cdr_locked)
      |=> !tx_en_q && !tx_data_q)
    else $error("Invalid code not muted.");

  force_on_a: assert property (
    ce && force_on |=> sd_eff_q)
    else $error("Force pattern did not force detect.");

  auto_detect_a: assert property (
    ce && sd_force_q[ROS_BIT_SD_ON:ROS_BIT_SD_OFF] == 2'b00
      |=> sd_eff_q == $past(sig_detect_raw))
    else $error("Detect not returned to automatic.");

  mute_code_a: assert property (
    ce && field_src == ROS_SRC_MUTE && !cdr_locked |=> !tx_en_q)
    else $error("Mute code drove the output.");

endmodule
`default_nettype wire

// File: verif/ros_stream_src.sv
/*
  Stand-in for the CDR, PRBS and oscillator stream outputs.
  Assumes one clock; each stream walks its own 8-cycle pattern.
*/
`timescale 1ns/1ps
`default_nettype none
module ros_stream_src
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  output var  ros_pkg::ros_streams_t streams
);
  import ros_pkg::*;
  logic [2:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  // Distinct patterns, so a wrong selection cannot match by luck.
  assign streams = {cnt_q[0], cnt_q[1], cnt_q[2], cnt_q[0] ^ cnt_q[1],
                    cnt_q[1] ^ cnt_q[2], cnt_q[0] ^ cnt_q[2]};
endmodule
`default_nettype wire

// File: verif/tb_retimer_output_select.sv
/*
  Self-checking bench for the output source selector.
  Assumes ros_top and the stream source model; ce is held high except during the clock enable test.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_retimer_output_select;
  import ros_pkg::*;
  logic         clk, rst_n, ce, sd, lock;
  logic         tx, tx_en, sd_eff, prbs_en, qclk_en, cap_dis;
  logic [7:0]   rdata;
  ros_reg_req_t req;
  ros_streams_t streams;
  int           n_mismatch, checks, cycles, i;

  ros_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rdata_q(rdata), .sig_detect_raw(sd), .cdr_locked(lock),
    .streams(streams), .tx_data_q(tx), .tx_en_q(tx_en),
    .sd_eff_q(sd_eff), .prbs_en_q(prbs_en), .qclk_en_q(qclk_en),
    .cap_research_dis_q(cap_dis));
  ros_stream_src src (.clk(clk), .rst_n(rst_n), .streams(streams));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A hang past this many cycles is counted as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results;
    end
  end

  task automatic cmp(input string what, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) req.addr <= a;
    @(posedge clk);
    @(negedge clk) cmp("rdata", e, rdata);
  endtask

  function automatic logic pick(input logic [2:0] c, input ros_streams_t s);
    case (c)
      3'h0: return s.raw;
      3'h1: return s.retimed;
      3'h2: return s.iclk;
      3'h3: return s.qclk;
      3'h4: return s.prbs;
      3'h5: return s.slow_clk;
      default: return 1'b0;
    endcase
  endfunction

  // Streams seen before an edge must show on tx after that edge. Every
  // cycle of a full 8-step lap is checked, so no two sources look alike.
  task automatic watch(input logic [2:0] c, input logic pwr);
    ros_streams_t s;
    logic e;
    e = pwr && (c < 3'h6);
    @(negedge clk) s = streams;
    repeat (8) begin
      @(negedge clk) cmp("tx_en", {7'h0, e}, {7'h0, tx_en});
      cmp("tx_data", {7'h0, e & pick(c, s)}, {7'h0, tx});
      s = streams;
    end
  endtask

  task automatic flags(input logic [2:0] e);
    repeat (2) @(posedge clk);
    @(negedge clk) cmp("flags", {5'h0, e}, {5'h0, prbs_en, qclk_en, cap_dis});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wr(8'hFF, 8'h00);
    rd(ROS_OFF_OVERRIDE, 8'h00);
    rd(ROS_OFF_SD_FORCE, 8'h00);
    rd(ROS_OFF_SRC_SEL, 8'hE0);
    rd(ROS_OFF_CAP_CTRL, 8'h00);
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    watch(3'h7, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_mux(input logic ovr);
    @(posedge clk) lock <= ovr;
    wr(ROS_OFF_CAP_CTRL, 8'h80);
    wr(ROS_OFF_OVERRIDE, {2'h0, ovr, 5'h10});
    for (i = 0; i < 8; i++) begin
      wr(ROS_OFF_SRC_SEL, {i[2:0], 5'h11});
      watch(i[2:0], 1'b1);
    end
    rd(ROS_OFF_SRC_SEL, 8'hF1);
    $display("mux test done");
  endtask

  task automatic t_lock;
    @(posedge clk) sd <= 1'b1;
    watch(3'h7, 1'b1);
    @(posedge clk) lock <= 1'b1;
    watch(3'h1, 1'b1);
    $display("lock test done");
  endtask

  task automatic t_detect;
    flags(3'h7);
    wr(ROS_OFF_SRC_SEL, 8'h91);
    @(posedge clk) sd <= 1'b0;
    watch(3'h4, 1'b0);
    wr(ROS_OFF_SD_FORCE, 8'h80);
    watch(3'h4, 1'b1);
    cmp("sd_eff", 8'h01, {7'h0, sd_eff});
    wr(ROS_OFF_SD_FORCE, 8'hC0);
    watch(3'h4, 1'b0);
    wr(ROS_OFF_SD_FORCE, 8'h40);
    watch(3'h4, 1'b0);
    wr(ROS_OFF_SD_FORCE, 8'h00);
    @(posedge clk) sd <= 1'b1;
    watch(3'h4, 1'b1);
    wr(ROS_OFF_OVERRIDE, 8'h20);
    flags(3'h5);
    wr(ROS_OFF_SRC_SEL, 8'h81);
    wr(ROS_OFF_CAP_CTRL, 8'h00);
    flags(3'h0);
    $display("detect and enable test done");
  endtask

  // A write offered while the clock enable is low must leave no trace.
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    wr(ROS_OFF_OVERRIDE, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd(ROS_OFF_OVERRIDE, 8'h20);
    $display("clock enable test done");
  endtask

  initial begin
    ce = 1'b1;
    sd = 1'b0;
    lock = 1'b0;
    req = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_lock;
    t_mux(1'b0);
    t_mux(1'b1);
    t_detect;
    t_ce;
    results;
  end
endmodule
`default_nettype wire
